// >>> rtl/dold_cfg.svh
// constants for the drive output level detectors
`ifndef DOLD_CFG_SVH
`define DOLD_CFG_SVH

// clock and timer base, in nanoseconds
`define DOLD_CLK_PERIOD_NS   10
`define DOLD_TICK_PERIOD_NS  10000000
`define DOLD_ZC_HOLD_NS      100000000

// "use other setting" / "hold until next start" marker value
`define DOLD_FREQ_SENTINEL   16'h270F
`define DOLD_TIME_SENTINEL   14'h270F

// scaling: band is in percent of set frequency, current is in 0.1 % of rated
`define DOLD_PCT_FULL        7'h64
`define DOLD_CUR_PER_PCT     4'hA

// terminal selection codes, non-inverted and inverted
`define DOLD_SEL_SU_POS      8'h01
`define DOLD_SEL_SU_NEG      8'h65
`define DOLD_SEL_FU_POS      8'h04
`define DOLD_SEL_FU_NEG      8'h68
`define DOLD_SEL_OC_POS      8'h0C
`define DOLD_SEL_OC_NEG      8'h70
`define DOLD_SEL_ZC_POS      8'h0D
`define DOLD_SEL_ZC_NEG      8'h71

// tick divider reset value and counter step
`define DOLD_CNT_ZERO        20'h00000
`define DOLD_CNT_ONE         20'h00001

`endif

// >>> rtl/dold_pkg.sv
// types shared by the drive output level detector design
package dold_pkg;
    typedef logic [15:0] dold_freq_t;   // 0.1 Hz units
    typedef logic [7:0]  dold_pct_t;    // whole percent
    typedef logic [11:0] dold_cur_t;    // 0.1 % of rated current
    typedef logic [13:0] dold_time_t;   // 10 ms ticks
    typedef logic [7:0]  dold_tsel_t;   // terminal selection code

    typedef enum logic [1:0] {
        OC_IDLE,
        OC_ACTIVE,
        OC_RETAIN,
        OC_LATCHED
    } dold_oc_state_t;

    typedef enum logic [1:0] {
        ZC_OFF,
        ZC_HOLD,
        ZC_ON
    } dold_zc_state_t;
endpackage : dold_pkg

// >>> rtl/dold_timer.sv
// tick-counting qualify timer: expires once run has held for limit ticks
module dold_timer #(
    parameter int W = 14
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // timing
    input  wire logic         tick,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    // result
    output logic              expired
);
    logic [W-1:0] cnt_q;

    // restart as soon as the qualifying condition lapses
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= '0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
        end
        else if (tick && (cnt_q < limit))
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // a limit of zero expires in the same cycle the condition appears
    assign expired = run && (cnt_q >= limit);
endmodule : dold_timer

// >>> rtl/dold_top.sv
// drive output level detectors: frequency, overcurrent and zero-current flags
`include "dold_cfg.svh"

// Contract
// [R1] up_to_freq asserts when output frequency is within band of set frequency.
// [R2] band is percent of set frequency, 0 to 100, default 10.
// [R3] selection codes 1 and 101 route up_to_freq to a terminal.
// [R4] freq_reached asserts while output frequency is at or above forward threshold.
// [R5] reverse threshold used in reverse unless 9999; then forward threshold everywhere.
// [R6] selection codes 4 and 104 route freq_reached to a terminal.
// [R7] DC injection braking forces all frequency flags off.
// [R8] comparisons use output frequency before slip compensation.
// [R9] current detection only while running; stopped means no detection.
// [R10] overcurrent flag asserts after current exceeds level for the delay time.
// [R11] overcurrent level is percent of rated current, 0 to 200, default 150.
// [R12] overcurrent flag held for the retention time once asserted.
// [R13] retention 9999 holds overcurrent flag until the next start.
// [R14] action 0 keeps running; action 1 trips with overcurrent fault.
// [R15] zero_current asserts after current stays below level for the set time.
// [R16] zero-current level is percent of rated current, 0 to 200, default 5.
// [R17] selection codes 12 and 112 route the overcurrent flag to a terminal.
// [R18] selection codes 13 and 113 route zero_current to a terminal.
// [R19] zero_current stays on about 0.1 s once turned on.
// [R20] enabling trip while flag is on trips nothing until flag clears.
// [R21] non-inverted codes drive terminal active high, inverted codes active low.
// [R22] timers count a fixed tick and restart when their condition lapses.
module dold_top
#(
    parameter int TICK_CYCLES = `DOLD_TICK_PERIOD_NS / `DOLD_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    // drive core state
    input  wire logic          run_active,
    input  wire logic          start_cmd,
    input  wire logic          dc_brake_active,
    input  wire logic          reverse_dir,
    input  dold_pkg::dold_freq_t out_freq_raw,
    input  dold_pkg::dold_freq_t set_freq,
    input  dold_pkg::dold_cur_t  out_current,
    // frequency detection settings
    input  dold_pkg::dold_pct_t  sensitivity_band,
    input  dold_pkg::dold_freq_t forward_freq_threshold,
    input  dold_pkg::dold_freq_t reverse_freq_threshold,
    // current detection settings
    input  dold_pkg::dold_pct_t  overcurrent_level,
    input  dold_pkg::dold_time_t overcurrent_delay,
    input  dold_pkg::dold_time_t overcurrent_retention,
    input  wire logic            overcurrent_action,
    input  dold_pkg::dold_pct_t  zero_current_level,
    input  dold_pkg::dold_time_t zero_current_time,
    // terminal assignment
    input  dold_pkg::dold_tsel_t terminal_select_a,
    input  dold_pkg::dold_tsel_t terminal_select_b,
    input  dold_pkg::dold_tsel_t terminal_select_c,
    // status flags
    output logic               up_to_freq,
    output logic               freq_reached,
    output logic               overcurrent_flag,
    output logic               zero_current,
    output logic               overcurrent_fault,
    // output terminals
    output logic               term_a,
    output logic               term_b,
    output logic               term_c
);
    import dold_pkg::*;

    localparam int            TICK_W          = 20;
    localparam logic [TICK_W-1:0] TICK_LAST   = TICK_W'(TICK_CYCLES - 1);
    localparam int            ZC_HOLD_TICKS_I = `DOLD_ZC_HOLD_NS / `DOLD_TICK_PERIOD_NS;
    localparam dold_time_t    ZC_HOLD_TICKS   = dold_time_t'(ZC_HOLD_TICKS_I < 1 ? 1 : ZC_HOLD_TICKS_I);

    logic [TICK_W-1:0] tick_cnt_q;
    logic              tick_q;
    logic [23:0]       freq_diff_x100;
    logic [23:0]       band_width;
    logic [15:0]       freq_diff;
    dold_freq_t        freq_thr;
    logic              su_raw;
    logic              fu_raw;
    logic [15:0]       oc_limit;
    logic [15:0]       zc_limit;
    logic [15:0]       cur_ext;
    logic              oc_cond;
    logic              zc_cond;
    logic              oc_hit;
    logic              zc_hit;
    logic              ret_expired;
    logic              zc_hold_done;
    logic              ret_forever;
    dold_oc_state_t    oc_q;
    dold_oc_state_t    oc_d;
    dold_zc_state_t    zc_q;
    dold_zc_state_t    zc_d;
    dold_tsel_t        tsel   [3];
    logic [2:0]        term_d;

    // fixed-period tick; one-cycle enable so everything stays on core_clk
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tick_cnt_q <= `DOLD_CNT_ZERO;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q >= TICK_LAST)
        begin
            tick_cnt_q <= `DOLD_CNT_ZERO;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + `DOLD_CNT_ONE;
            tick_q     <= 1'b0;
        end
    end

    // frequency comparisons on the uncompensated output frequency [R8]
    always_comb
    begin
        freq_diff = (out_freq_raw >= set_freq) ? (out_freq_raw - set_freq)
                                               : (set_freq - out_freq_raw);
        // cross-multiplied so no divider is needed
        freq_diff_x100 = 24'(freq_diff * `DOLD_PCT_FULL); // [R2]
        band_width     = 24'(set_freq * sensitivity_band); // [R2]
        su_raw         = (freq_diff_x100 <= band_width); // [R1]
    end

    always_comb
    begin
        // 9999 means the forward threshold covers both directions
        if (reverse_dir && (reverse_freq_threshold != `DOLD_FREQ_SENTINEL))
        begin
            freq_thr = reverse_freq_threshold; // [R5]
        end
        else
        begin
            freq_thr = forward_freq_threshold; // [R5]
        end
        fu_raw = (out_freq_raw >= freq_thr); // [R4]
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            up_to_freq   <= 1'b0;
            freq_reached <= 1'b0;
        end
        else
        begin
            up_to_freq   <= su_raw && !dc_brake_active; // [R1] [R7]
            freq_reached <= fu_raw && !dc_brake_active; // [R4] [R7]
        end
    end

    // current thresholds scaled from whole percent to 0.1 % units
    always_comb
    begin
        oc_limit = 16'(overcurrent_level * `DOLD_CUR_PER_PCT); // [R11]
        zc_limit = 16'(zero_current_level * `DOLD_CUR_PER_PCT); // [R16]
        cur_ext  = {4'h0, out_current};
        oc_cond  = run_active && (cur_ext > oc_limit); // [R9] [R10]
        // a zero level turns zero-current detection off
        zc_cond  = run_active && (zero_current_level != '0) && (cur_ext < zc_limit); // [R9] [R15]
        ret_forever = (overcurrent_retention == `DOLD_TIME_SENTINEL);
    end

    dold_timer #(
        .W (14)
    ) u_oc_delay (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tick     (tick_q),
        .run      (oc_cond),
        .limit    (overcurrent_delay),
        .expired  (oc_hit)
    ); // [R10] [R22]
    dold_timer #(
        .W (14)
    ) u_oc_retain (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tick     (tick_q),
        .run      (oc_q == OC_RETAIN),
        .limit    (overcurrent_retention),
        .expired  (ret_expired)
    ); // [R12] [R22]
    dold_timer #(
        .W (14)
    ) u_zc_time (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tick     (tick_q),
        .run      (zc_cond),
        .limit    (zero_current_time),
        .expired  (zc_hit)
    ); // [R15] [R22]

    dold_timer #(
        .W (14)
    ) u_zc_hold (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tick     (tick_q),
        .run      (zc_q == ZC_HOLD),
        .limit    (ZC_HOLD_TICKS),
        .expired  (zc_hold_done)
    ); // [R19] [R22]

    // overcurrent flag sequencing: detect, hold for retention, or latch to next start
    always_comb
    begin
        oc_d = oc_q;
        unique case (oc_q)
            OC_IDLE:
            begin
                if (oc_hit)
                begin
                    oc_d = OC_ACTIVE; // [R10]
                end
            end
            OC_ACTIVE:
            begin
                if (!oc_hit)
                begin
                    oc_d = ret_forever ? OC_LATCHED : OC_RETAIN; // [R12] [R13]
                end
            end
            OC_RETAIN:
            begin
                if (oc_hit)
                begin
                    oc_d = OC_ACTIVE;
                end
                else if (ret_expired)
                begin
                    oc_d = OC_IDLE; // [R12]
                end
            end
            OC_LATCHED:
            begin
                // only a new start releases the latched flag
                if (start_cmd)
                begin
                    oc_d = OC_IDLE; // [R13]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            oc_q             <= OC_IDLE;
            overcurrent_flag <= 1'b0;
        end
        else
        begin
            oc_q             <= oc_d;
            overcurrent_flag <= (oc_d != OC_IDLE); // [R12]
        end
    end

    // trip only on the flag's rising edge, so arming the action while the
    // flag is already on has no effect until it has dropped [R20]
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            overcurrent_fault <= 1'b0;
        end
        else if (overcurrent_action && !overcurrent_flag && (oc_d != OC_IDLE))
        begin
            overcurrent_fault <= 1'b1; // [R14] [R20]
        end
    end

    // zero-current flag with a minimum on-time
    always_comb
    begin
        zc_d = zc_q;
        unique case (zc_q)
            ZC_OFF:
            begin
                if (zc_hit)
                begin
                    zc_d = ZC_HOLD; // [R15]
                end
            end
            ZC_HOLD:
            begin
                if (zc_hold_done)
                begin
                    zc_d = zc_hit ? ZC_ON : ZC_OFF; // [R19]
                end
            end
            ZC_ON:
            begin
                if (!zc_hit)
                begin
                    zc_d = ZC_OFF;
                end
            end
            default:
            begin
                zc_d = ZC_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            zc_q         <= ZC_OFF;
            zero_current <= 1'b0;
        end
        else
        begin
            zc_q         <= zc_d;
            zero_current <= (zc_d != ZC_OFF); // [R15] [R19]
        end
    end

    // terminal routing, one selector per terminal
    assign tsel[0] = terminal_select_a;
    assign tsel[1] = terminal_select_b;
    assign tsel[2] = terminal_select_c;

    for (genvar t = 0; t < 3; t++)
    begin : g_term
        always_comb
        begin
            unique case (tsel[t])
                `DOLD_SEL_SU_POS: term_d[t] = up_to_freq; // [R3] [R21]
                `DOLD_SEL_SU_NEG: term_d[t] = !up_to_freq; // [R3] [R21]
                `DOLD_SEL_FU_POS: term_d[t] = freq_reached; // [R6] [R21]
                `DOLD_SEL_FU_NEG: term_d[t] = !freq_reached; // [R6] [R21]
                `DOLD_SEL_OC_POS: term_d[t] = overcurrent_flag; // [R17] [R21]
                `DOLD_SEL_OC_NEG: term_d[t] = !overcurrent_flag; // [R17] [R21]
                `DOLD_SEL_ZC_POS: term_d[t] = zero_current; // [R18] [R21]
                `DOLD_SEL_ZC_NEG: term_d[t] = !zero_current; // [R18] [R21]
                // any other code drives the terminal low
                default:          term_d[t] = 1'b0;
            endcase
        end
    end

    // registered so terminals never glitch while settings change
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            term_a <= 1'b0;
            term_b <= 1'b0;
            term_c <= 1'b0;
        end
        else
        begin
            term_a <= term_d[0];
            term_b <= term_d[1];
            term_c <= term_d[2];
        end
    end
endmodule : dold_top

// >>> bench/dold_monitor.sv
// concurrent checks on the ports of the drive output level detectors
`include "dold_cfg.svh"
module dold_monitor
(
    // clock and reset
    input wire logic           core_clk,
    input wire logic           rstn,
    // drive core and settings
    input wire logic           run_active,
    input wire logic           dc_brake_active,
    input wire logic           reverse_dir,
    input wire logic           overcurrent_action,
    input dold_pkg::dold_freq_t out_freq_raw,
    input dold_pkg::dold_freq_t set_freq,
    input dold_pkg::dold_freq_t forward_freq_threshold,
    input dold_pkg::dold_freq_t reverse_freq_threshold,
    input dold_pkg::dold_cur_t  out_current,
    input dold_pkg::dold_pct_t  sensitivity_band,
    input dold_pkg::dold_pct_t  overcurrent_level,
    input dold_pkg::dold_pct_t  zero_current_level,
    input dold_pkg::dold_time_t overcurrent_delay,
    input dold_pkg::dold_tsel_t terminal_select_a,
    input dold_pkg::dold_tsel_t terminal_select_b,
    input dold_pkg::dold_tsel_t terminal_select_c,
    // flags and terminals
    input wire logic           up_to_freq,
    input wire logic           freq_reached,
    input wire logic           overcurrent_flag,
    input wire logic           zero_current,
    input wire logic           overcurrent_fault,
    input wire logic           term_a,
    input wire logic           term_b,
    input wire logic           term_c
);
    timeunit 1ns;
    timeprecision 1ps;
    import dold_pkg::*;
    logic [1:0] live_q;
    logic       live, su_c, fu_c, oc_c, zc_c;
    logic [2:0] map_c;
    dold_freq_t thr, dif;
    function automatic logic tmap(input dold_tsel_t s, input logic [3:0] f);
        case (s)
            `DOLD_SEL_SU_POS: return f[3];
            `DOLD_SEL_SU_NEG: return !f[3];
            `DOLD_SEL_FU_POS: return f[2];
            `DOLD_SEL_FU_NEG: return !f[2];
            `DOLD_SEL_OC_POS: return f[1];
            `DOLD_SEL_OC_NEG: return !f[1];
            `DOLD_SEL_ZC_POS: return f[0];
            `DOLD_SEL_ZC_NEG: return !f[0];
            default: return 1'b0;
        endcase
    endfunction : tmap
    // outputs settle a few edges after release, so checks start late
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn)
            live_q <= 2'h0;
        else if (live_q != 2'h3)
            live_q <= live_q + 2'h1;
    always_comb
    begin
        live = live_q == 2'h3;
        thr = (reverse_dir && reverse_freq_threshold != `DOLD_FREQ_SENTINEL) ? reverse_freq_threshold
            : forward_freq_threshold;
        dif = (out_freq_raw > set_freq) ? out_freq_raw - set_freq : set_freq - out_freq_raw;
        su_c = 32'(dif) * 32'h64 <= 32'(set_freq) * 32'(sensitivity_band);
        fu_c = out_freq_raw >= thr;
        oc_c = run_active && 32'(out_current) > 32'(overcurrent_level) * 32'hA;
        zc_c = run_active && zero_current_level != 8'h00 && 32'(out_current) < 32'(zero_current_level) * 32'hA;
        map_c[2] = tmap(terminal_select_a, {up_to_freq, freq_reached, overcurrent_flag, zero_current});
        map_c[1] = tmap(terminal_select_b, {up_to_freq, freq_reached, overcurrent_flag, zero_current});
        map_c[0] = tmap(terminal_select_c, {up_to_freq, freq_reached, overcurrent_flag, zero_current});
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_brake_forces_off: assert property (live && dc_brake_active |=> !up_to_freq && !freq_reached)
        else $error("frequency flag set during braking");
    a_fu_follows: assert property (live && !dc_brake_active |=> freq_reached == $past(fu_c))
        else $error("freq_reached wrong");
    a_su_follows: assert property (live && !dc_brake_active |=> up_to_freq == $past(su_c))
        else $error("up_to_freq wrong");
    a_oc_no_delay: assert property (live && oc_c && overcurrent_delay == 14'h0 |=> overcurrent_flag)
        else $error("overcurrent flag late");
    a_oc_has_cause: assert property (live && $rose(overcurrent_flag) |-> $past(oc_c) || $past(oc_c, 2))
        else $error("overcurrent flag without cause");
    a_zc_has_cause: assert property (live && $rose(zero_current) |-> $past(zc_c) || $past(zc_c, 2))
        else $error("zero_current without cause");
    a_zc_min_hold: assert property (live && $rose(zero_current) |-> zero_current [*8])
        else $error("zero_current dropped early");
    a_trip_on_rise: assert property (live && $rose(overcurrent_fault) |-> $rose(overcurrent_flag)
        && $past(overcurrent_action))
        else $error("trip without flag rise");
    a_fault_sticky: assert property (overcurrent_fault |=> overcurrent_fault)
        else $error("fault cleared");
    a_term_map: assert property (live |=> {term_a, term_b, term_c} == $past(map_c))
        else $error("terminal level wrong");
endmodule : dold_monitor

// >>> bench/dold_drive_model.sv
// drive core run and start sequencing as seen by the detectors
module dold_drive_model
(
    // clock
    input wire logic core_clk,
    // request from the bench
    input wire logic want_run,
    // drive core state
    output logic     run_active,
    output logic     start_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic want_q;
    // request taken on the rising edge, so a falling-edge change by the bench never races this model
    always @(posedge core_clk)
        want_q <= want_run;
    // every new run opens with a one-cycle start pulse
    always @(negedge core_clk)
    begin
        start_cmd <= want_q && !run_active;
        run_active <= want_q;
    end
endmodule : dold_drive_model

// >>> bench/tb_top.sv
// self-checking bench for the drive output level detectors
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dold_pkg::*;
    localparam int TICKS = 4;
    logic       core_clk, rstn, want_run, run_active, start_cmd, dc_brake_active, reverse_dir;
    logic       overcurrent_action, up_to_freq, freq_reached, overcurrent_flag, zero_current;
    logic       overcurrent_fault, term_a, term_b, term_c;
    dold_freq_t out_freq_raw, set_freq, forward_freq_threshold, reverse_freq_threshold;
    dold_cur_t  out_current;
    dold_pct_t  sensitivity_band, overcurrent_level, zero_current_level;
    dold_time_t overcurrent_delay, overcurrent_retention, zero_current_time;
    dold_tsel_t terminal_select_a, terminal_select_b, terminal_select_c;
    dold_tsel_t codes [8] = '{8'h01, 8'h65, 8'h04, 8'h68, 8'h0C, 8'h70, 8'h0D, 8'h71};
    int         n_fail, check_count;
    dold_top #(.TICK_CYCLES(TICKS)) i_dold_top (.*);
    dold_drive_model i_dold_drive_model (.*);
    always #5 core_clk = ~core_clk;
    task automatic check(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    function automatic logic flag(input int w);
        return w ? zero_current : overcurrent_flag;
    endfunction : flag
    // bounded wait for a current flag to reach a level
    task automatic wait_flag(input int w, input logic v, input int lim);
        for (int i = 0; i < lim && flag(w) !== v; i++)
            @(negedge core_clk);
        check("wait", flag(w), v);
        if (flag(w) !== v)
            finish_test();
    endtask : wait_flag
    // drive one frequency picture and compare both flags an edge later
    task automatic fcase(input int f, input int s, input int b, input int fw, input int rv, input logic dir,
                         input logic brk);
        int d;
        out_freq_raw = 16'(f);
        set_freq = 16'(s);
        sensitivity_band = 8'(b);
        forward_freq_threshold = 16'(fw);
        reverse_freq_threshold = 16'(rv);
        reverse_dir = dir;
        dc_brake_active = brk;
        d = (f > s) ? f - s : s - f;
        cyc(1);
        check("up_to_freq", up_to_freq, !brk && d * 100 <= s * b);
        check("freq_reached", freq_reached, !brk && f >= ((dir && rv != 9999) ? rv : fw));
    endtask : fcase
    initial
    begin
        {core_clk, rstn, want_run, dc_brake_active, reverse_dir, overcurrent_action} = '0;
        {out_freq_raw, set_freq, out_current, sensitivity_band, zero_current_level} = '0;
        forward_freq_threshold = 16'h003C;
        reverse_freq_threshold = 16'h270F;
        overcurrent_level = 8'h96;
        overcurrent_delay = 14'h0000;
        overcurrent_retention = 14'h0002;
        zero_current_time = 14'h0003;
        {terminal_select_a, terminal_select_b, terminal_select_c} = {8'h01, 8'h68, 8'h0C};
        void'($urandom(60108));
        cyc(5);
        rstn = 1'b1;
        cyc(3);
        fcase(1100, 1000, 10, 1100, 9999, 1'b0, 1'b0);
        fcase(1101, 1000, 10, 1102, 1101, 1'b1, 1'b0);
        fcase(900, 1000, 10, 900, 9999, 1'b1, 1'b1);
        fcase(0, 0, 0, 0, 4000, 1'b1, 1'b0);
        repeat (400)
        begin
            terminal_select_a = codes[$urandom_range(7)];
            terminal_select_b = codes[$urandom_range(7)];
            terminal_select_c = codes[$urandom_range(7)];
            set_freq = 16'($urandom_range(4000));
            fcase($urandom_range(set_freq + 400, (set_freq > 400) ? set_freq - 400 : 0), set_freq,
                  $urandom_range(100), $urandom_range(4000), $urandom_range(1) ? 9999 : $urandom_range(4000),
                  1'($urandom_range(1)), $urandom_range(7) == 0);
        end
        out_current = 12'h708;
        cyc(20);
        check("overcurrent_flag", overcurrent_flag, 1'b0);
        want_run = 1'b1;
        cyc(3);
        check("overcurrent_flag", overcurrent_flag, 1'b1);
        overcurrent_action = 1'b1;
        cyc(2);
        out_current = 12'h5DC;
        wait_flag(0, 1'b0, 40);
        check("overcurrent_fault", overcurrent_fault, 1'b0);
        overcurrent_delay = 14'h0005;
        out_current = 12'h5DD;
        cyc(10);
        out_current = 12'h000;
        cyc(2);
        out_current = 12'h5DD;
        cyc(12);
        check("overcurrent_flag", overcurrent_flag, 1'b0);
        wait_flag(0, 1'b1, 20);
        check("overcurrent_fault", overcurrent_fault, 1'b1);
        out_current = 12'h000;
        cyc(4);
        check("overcurrent_flag", overcurrent_flag, 1'b1);
        wait_flag(0, 1'b0, 20);
        overcurrent_retention = 14'h270F;
        out_current = 12'h640;
        wait_flag(0, 1'b1, 40);
        out_current = 12'h000;
        cyc(60);
        check("overcurrent_flag", overcurrent_flag, 1'b1);
        want_run = 1'b0;
        cyc(2);
        want_run = 1'b1;
        cyc(3);
        check("overcurrent_flag", overcurrent_flag, 1'b0);
        zero_current_level = 8'h05;
        out_current = 12'h028;
        wait_flag(1, 1'b1, 30);
        out_current = 12'h1F4;
        cyc(20);
        check("zero_current", zero_current, 1'b1);
        wait_flag(1, 1'b0, 60);
        finish_test();
    end
endmodule : tb_top
bind dold_top dold_monitor i_dold_monitor (.*);
